// [verilog/afhp_pkg.sv]
package afhp_pkg;

  localparam int AFHP_DATA_W = 10;
  localparam int AFHP_DEPTH  = 16;
  localparam int AFHP_PTR_W  = 4;
  localparam int AFHP_CNT_W  = 5;
  localparam int AFHP_SYNC_W = 16;

  // Configuration reset values
  localparam logic [9:0] AFHP_MODE_RESET   = 10'h020;
  localparam logic [9:0] AFHP_FORMAT_RESET = 10'h000;

  // mode_channel_config field positions
  localparam int AFHP_M_VREF_BIT  = 0;
  localparam int AFHP_M_CONV_BIT  = 1;
  localparam int AFHP_M_PD_BIT    = 2;
  localparam int AFHP_M_PICK_LO   = 3;
  localparam int AFHP_M_BAL_LO    = 5;
  localparam int AFHP_M_SCAN_BIT  = 7;
  localparam int AFHP_M_TEST_LO   = 8;

  // buffer_format_config field positions
  localparam int AFHP_F_DEVRST_BIT = 0;
  localparam int AFHP_F_FLUSH_BIT  = 1;
  localparam int AFHP_F_TRIG_LO    = 2;
  localparam int AFHP_F_DATA_T_BIT = 4;
  localparam int AFHP_F_DATA_P_BIT = 5;
  localparam int AFHP_F_RW_BIT     = 6;
  localparam int AFHP_F_FMT_BIT    = 7;
  localparam int AFHP_F_OFFSET_BIT = 8;

  // Register select codes, {reg_select_hi, reg_select_lo}
  localparam logic [1:0] AFHP_SEL_MODE   = 2'h0;
  localparam logic [1:0] AFHP_SEL_FORMAT = 2'h1;

  // Samples swallowed by pipeline latency after a flush
  localparam logic [2:0] AFHP_LATENCY_SAMPLES = 3'h7;
  localparam logic [9:0] AFHP_SIGN_FLIP       = 10'h200;

  // Trigger levels in words, indexed by trigger code, per channel count
  localparam logic [3:0][4:0] AFHP_TRIG_1CH = {5'h0E, 5'h08, 5'h04, 5'h01};
  localparam logic [3:0][4:0] AFHP_TRIG_2CH = {5'h0C, 5'h08, 5'h04, 5'h02};
  localparam logic [3:0][4:0] AFHP_TRIG_3CH = {5'h0C, 5'h09, 5'h06, 5'h03};
  localparam logic [3:0][4:0] AFHP_TRIG_4CH = {5'h10, 5'h0C, 5'h08, 5'h04};

endpackage

// [verilog/afhp_sync.sv]
`timescale 1ns/1ps
module afhp_sync
  import afhp_pkg::*;
#(
  parameter int W = AFHP_SYNC_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } afhp_sync_state_type;

  afhp_sync_state_type s_reg;
  afhp_sync_state_type s_next;
  logic [W-1:0]        agree;

  always_comb begin
    s_next    = s_reg;
    agree     = ~(s_reg.s2 ^ s_reg.s3);
    s_next.s1 = async_in;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.q  = (s_reg.s2 & agree) | (s_reg.q & ~agree);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.q;

  property p_sync_agree;
    @(posedge clk) disable iff (rst)
    ((s_reg.q ^ $past(s_reg.q)) & ($past(s_reg.s2) ^ $past(s_reg.s3))) == '0;
  endproperty
  a_sync_agree: assert property (p_sync_agree)
    else $error("synchronised bit changed without agreement");

endmodule // afhp_sync

// [verilog/afhp_ring.sv]
`timescale 1ns/1ps
module afhp_ring
  import afhp_pkg::*;
#(
  parameter int W     = AFHP_DATA_W,
  parameter int DEPTH = AFHP_DEPTH,
  parameter int PW    = AFHP_PTR_W
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          flush,
  input  wire logic          push,
  input  wire logic [W-1:0]  push_data,
  input  wire logic          pop,
  output logic      [W-1:0]  pop_data,
  output logic               empty,
  output logic      [PW-1:0] wr_ptr,
  output logic      [PW-1:0] rd_ptr,
  output logic      [PW:0]   count
);

  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wr;
    logic [PW-1:0]           rd;
    logic [PW:0]             cnt;
  } afhp_ring_state_type;

  afhp_ring_state_type s_reg;
  afhp_ring_state_type s_next;
  logic                do_pop;
  logic                adv;
  logic [PW-1:0]       wr_inc;

  always_comb begin
    s_next = s_reg;
    do_pop = pop && (s_reg.cnt != '0);
    adv    = do_pop || (push && (s_reg.cnt == FULL_CNT));
    wr_inc = s_reg.wr + 1'b1;
    if (flush) begin
      s_next.wr  = '1;
      s_next.rd  = '0;
      s_next.cnt = '0;
    end else begin
      // Write pointer marks the last written entry
      if (push) begin
        s_next.wr          = wr_inc;
        s_next.mem[wr_inc] = push_data;
      end
      // Full buffer drops its oldest word on a push
      if (adv) begin
        s_next.rd = s_reg.rd + 1'b1;
      end
      if (push && !adv) begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end else if (!push && adv) begin
        s_next.cnt = s_reg.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{mem: '0, wr: '1, rd: '0, cnt: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign pop_data = s_reg.mem[s_reg.rd];
  assign empty    = (s_reg.cnt == '0);
  assign wr_ptr   = s_reg.wr;
  assign rd_ptr   = s_reg.rd;
  assign count    = s_reg.cnt;

  property p_ring_flush;
    @(posedge clk) disable iff (rst)
    flush |=> empty && (rd_ptr == '0) && (wr_ptr == '1);
  endproperty
  a_ring_flush: assert property (p_ring_flush)
    else $error("flush did not empty the buffer");

  property p_ring_wrptr;
    @(posedge clk) disable iff (rst)
    push && !flush |=> wr_ptr == PW'($past(wr_ptr) + 1'b1);
  endproperty
  a_ring_wrptr: assert property (p_ring_wrptr)
    else $error("write pointer did not advance on push");

  property p_ring_store;
    @(posedge clk) disable iff (rst)
    push && !flush && empty |=> pop_data == $past(push_data);
  endproperty
  a_ring_store: assert property (p_ring_store)
    else $error("first stored word not presented for reading");

  property p_ring_full_hold;
    @(posedge clk) disable iff (rst)
    push && !flush && (count == FULL_CNT) |=> count == FULL_CNT;
  endproperty
  a_ring_full_hold: assert property (p_ring_full_hold)
    else $error("full buffer lost its fill level on overwrite");

endmodule // afhp_ring

// [verilog/afhp_top.sv]
`timescale 1ns/1ps
module afhp_top
  import afhp_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       SAMPLE_VALID,
  input  wire logic [9:0] SAMPLE_CODE,
  output logic      [1:0] SCAN_CHANNEL,
  output logic      [9:0] MODE_CHANNEL_CONFIG,
  input  wire logic       CHIP_SELECT_LOW_ACTIVE_N,
  input  wire logic       CHIP_SELECT_HIGH_ACTIVE,
  input  wire logic       READ_N,
  input  wire logic       WRITE_N,
  input  wire logic       REG_SELECT_LO,
  input  wire logic       REG_SELECT_HI,
  input  wire logic [9:0] DATA_IN,
  output logic      [9:0] DATA_OUT,
  output logic            DATA_OE,
  output logic            BLOCK_READY_N
);

  typedef struct packed {
    logic [9:0] mode_cfg;
    logic [9:0] fmt_cfg;
    logic       rd_prev;
    logic       wr_prev;
    logic [1:0] scan_ch;
    logic [2:0] lat_cnt;
    logic [4:0] blk_cnt;
    logic       blk_n;
    logic [9:0] dout;
    logic       oe;
  } afhp_top_state_type;

  localparam afhp_top_state_type TOP_RESET = '{
    mode_cfg: AFHP_MODE_RESET,
    fmt_cfg:  AFHP_FORMAT_RESET,
    blk_n:    1'b1,
    default:  '0
  };

  afhp_top_state_type s_reg;
  afhp_top_state_type s_next;

  logic [AFHP_SYNC_W-1:0] pins_sync;
  logic                   cs_n_s;
  logic                   cs_s;
  logic                   rd_n_s;
  logic                   wr_n_s;
  logic [1:0]             sel_s;
  logic [9:0]             din_s;

  logic                   rd_eff;
  logic                   wr_eff;
  logic                   rd_start;
  logic                   wr_start;
  logic                   flush;
  logic                   twos;
  logic                   single_mode;
  logic                   test_on;
  logic                   lat_done;
  logic [2:0]             nch;
  logic [4:0]             tl;
  logic [4:0]             blk_inc;

  logic                   ring_push;
  logic [9:0]             ring_push_data;
  logic                   ring_pop;
  logic [9:0]             ring_pop_data;
  logic                   ring_empty;

  // Trigger level in words from channel count and trigger code
  function automatic logic [4:0] trig_words(input logic [2:0] n, input logic [1:0] code);
    logic [4:0] w;
    w = 5'h00;
    case (n)
      3'h1:    w = AFHP_TRIG_1CH[code];
      3'h2:    w = AFHP_TRIG_2CH[code];
      3'h3:    w = AFHP_TRIG_3CH[code];
      default: w = AFHP_TRIG_4CH[code];
    endcase
    return w;
  endfunction

  afhp_sync #(
    .W (AFHP_SYNC_W)
  ) u_sync (
    .clk      (CLK),
    .rst      (RST),
    .async_in ({CHIP_SELECT_LOW_ACTIVE_N, CHIP_SELECT_HIGH_ACTIVE, READ_N, WRITE_N,
                REG_SELECT_HI, REG_SELECT_LO, DATA_IN}),
    .sync_out (pins_sync)
  );

  assign {cs_n_s, cs_s, rd_n_s, wr_n_s, sel_s, din_s} = pins_sync;

  afhp_ring #(
    .W     (AFHP_DATA_W),
    .DEPTH (AFHP_DEPTH),
    .PW    (AFHP_PTR_W)
  ) u_ring (
    .clk       (CLK),
    .rst       (RST),
    .flush     (flush),
    .push      (ring_push),
    .push_data (ring_push_data),
    .pop       (ring_pop),
    .pop_data  (ring_pop_data),
    .empty     (ring_empty),
    .wr_ptr    (),
    .rd_ptr    (),
    .count     ()
  );

  always_comb begin
    s_next = s_reg;

    // Bus strobes from synchronised pins
    rd_eff   = ~cs_n_s & cs_s & ~rd_n_s;
    wr_eff   = ~cs_n_s & cs_s & ~wr_n_s;
    rd_start = rd_eff & ~s_reg.rd_prev;
    wr_start = wr_eff & ~s_reg.wr_prev;
    s_next.rd_prev = rd_eff;
    s_next.wr_prev = wr_eff;
    s_next.oe      = rd_eff;

    // Decoded configuration
    flush       = s_reg.fmt_cfg[AFHP_F_FLUSH_BIT] | s_reg.fmt_cfg[AFHP_F_DEVRST_BIT];
    twos        = s_reg.fmt_cfg[AFHP_F_FMT_BIT];
    single_mode = s_reg.mode_cfg[AFHP_M_CONV_BIT];
    test_on     = |s_reg.mode_cfg[AFHP_M_TEST_LO +: 2];
    nch         = s_reg.mode_cfg[AFHP_M_SCAN_BIT]
                ? 3'({1'b0, s_reg.mode_cfg[AFHP_M_PICK_LO +: 2]}) + 3'h1
                : 3'h1;
    tl          = trig_words(nch, s_reg.fmt_cfg[AFHP_F_TRIG_LO +: 2]);
    blk_inc     = s_reg.blk_cnt + 5'h01;

    // Flush and device reset bits clear themselves
    s_next.fmt_cfg[AFHP_F_FLUSH_BIT]  = 1'b0;
    s_next.fmt_cfg[AFHP_F_DEVRST_BIT] = 1'b0;
    if (s_reg.fmt_cfg[AFHP_F_DEVRST_BIT]) begin
      s_next.mode_cfg = AFHP_MODE_RESET;
      s_next.fmt_cfg  = AFHP_FORMAT_RESET;
    end else if (wr_start) begin
      case (sel_s)
        AFHP_SEL_MODE:   s_next.mode_cfg = din_s;
        AFHP_SEL_FORMAT: s_next.fmt_cfg  = din_s;
        default:         ;
      endcase
    end

    // Conversion results; inputs are idle in power down
    lat_done       = single_mode || (s_reg.lat_cnt == AFHP_LATENCY_SAMPLES);
    ring_push      = SAMPLE_VALID && !s_reg.mode_cfg[AFHP_M_PD_BIT] && lat_done && !flush;
    ring_push_data = twos ? (SAMPLE_CODE ^ AFHP_SIGN_FLIP) : SAMPLE_CODE;
    s_next.blk_n   = 1'b1;

    if (flush) begin
      s_next.scan_ch = 2'h0;
      s_next.lat_cnt = 3'h0;
      s_next.blk_cnt = 5'h00;
    end else if (SAMPLE_VALID && !s_reg.mode_cfg[AFHP_M_PD_BIT] && !lat_done) begin
      s_next.lat_cnt = s_reg.lat_cnt + 3'h1;
    end else if (ring_push) begin
      // Scan order restarts at the first channel
      if (3'({1'b0, s_reg.scan_ch}) + 3'h1 >= nch) begin
        s_next.scan_ch = 2'h0;
      end else begin
        s_next.scan_ch = s_reg.scan_ch + 2'h1;
      end
      if (blk_inc >= tl) begin
        s_next.blk_cnt = 5'h00;
        s_next.blk_n   = test_on;
      end else begin
        s_next.blk_cnt = blk_inc;
      end
    end

    // Host reads; the mode register has no read path
    ring_pop = 1'b0;
    if (rd_start) begin
      if (sel_s == AFHP_SEL_MODE) begin
        s_next.dout = ring_pop_data;
        ring_pop    = 1'b1;
      end else if (sel_s == AFHP_SEL_FORMAT && s_reg.fmt_cfg[AFHP_F_RW_BIT]) begin
        s_next.dout = s_reg.fmt_cfg;
      end else begin
        s_next.dout = 10'h000;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_reg <= TOP_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign SCAN_CHANNEL        = s_reg.scan_ch;
  assign MODE_CHANNEL_CONFIG = s_reg.mode_cfg;
  assign DATA_OUT            = s_reg.dout;
  assign DATA_OE             = s_reg.oe;
  assign BLOCK_READY_N       = s_reg.blk_n;

  property p_fmt_binary;
    @(posedge CLK) disable iff (RST)
    ring_push && !twos |-> ring_push_data == SAMPLE_CODE;
  endproperty
  a_fmt_binary: assert property (p_fmt_binary)
    else $error("binary format altered the code");

  property p_fmt_twos;
    @(posedge CLK) disable iff (RST)
    ring_push && twos |-> (ring_push_data ^ SAMPLE_CODE) == 10'h200;
  endproperty
  a_fmt_twos: assert property (p_fmt_twos)
    else $error("twos complement format not a sign flip");

  property p_pulse_single;
    @(posedge CLK) disable iff (RST)
    !BLOCK_READY_N |=> BLOCK_READY_N;
  endproperty
  a_pulse_single: assert property (p_pulse_single)
    else $error("block ready held low beyond one cycle");

  property p_pulse_count;
    @(posedge CLK) disable iff (RST)
    $fell(BLOCK_READY_N) |-> $past(ring_push) && ($past(blk_inc) >= $past(tl));
  endproperty
  a_pulse_count: assert property (p_pulse_count)
    else $error("block ready without reaching trigger level");

  property p_test_quiet;
    @(posedge CLK) disable iff (RST)
    test_on |=> BLOCK_READY_N;
  endproperty
  a_test_quiet: assert property (p_test_quiet)
    else $error("block ready pulsed during test selection");

  property p_write_mode;
    @(posedge CLK) disable iff (RST)
    wr_start && (sel_s == AFHP_SEL_MODE) && !s_reg.fmt_cfg[AFHP_F_DEVRST_BIT]
      |=> MODE_CHANNEL_CONFIG == $past(din_s);
  endproperty
  a_write_mode: assert property (p_write_mode)
    else $error("mode register write not taken");

  property p_reserved_sel;
    @(posedge CLK) disable iff (RST)
    wr_start && sel_s[1] && !s_reg.fmt_cfg[AFHP_F_DEVRST_BIT]
      |=> $stable(MODE_CHANNEL_CONFIG);
  endproperty
  a_reserved_sel: assert property (p_reserved_sel)
    else $error("reserved select changed a register");

  property p_latency;
    @(posedge CLK) disable iff (RST)
    ring_push && !single_mode |-> s_reg.lat_cnt == AFHP_LATENCY_SAMPLES;
  endproperty
  a_latency: assert property (p_latency)
    else $error("result stored inside pipeline latency");

  property p_read_data;
    @(posedge CLK) disable iff (RST)
    rd_start && (sel_s == AFHP_SEL_MODE) && !ring_empty |=> DATA_OUT == $past(ring_pop_data);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("buffer read returned wrong word");

endmodule // afhp_top

// [testbench/afhp_host_model.sv]
`timescale 1ns/1ps
module afhp_host_model (
  input  wire logic       clk,
  input  wire logic [9:0] data_out,
  input  wire logic       data_oe,
  output logic            cs_n,
  output logic            cs,
  output logic            read_n,
  output logic            write_n,
  output logic            sel_lo,
  output logic            sel_hi,
  output logic      [9:0] data_in
);
  initial begin
    cs_n    = 1'b1;
    cs      = 1'b0;
    read_n  = 1'b1;
    write_n = 1'b1;
    sel_lo  = 1'b0;
    sel_hi  = 1'b0;
    data_in = 10'h000;
  end

  // One bus access; select and data settle four edges before the strobe
  task automatic access(input logic [1:0] sel, input logic wr, input logic cs_ok,
                        input logic [9:0] d, output logic [9:0] rd, output logic seen);
    seen = 1'b0;
    rd   = 10'h000;
    {sel_hi, sel_lo} = sel;
    data_in = d;
    repeat (4) @(negedge clk);
    cs_n    = 1'b0;
    cs      = cs_ok;
    read_n  = wr;
    write_n = ~wr;
    if (wr) begin
      repeat (6) @(negedge clk);
    end else begin
      // Answer taken once settled, away from its launching edge
      for (int i = 0; i < 10 && !seen; i++) begin
        @(negedge clk);
        if (data_oe === 1'b1) begin
          seen = 1'b1;
          rd   = data_out;
        end
      end
    end
    cs_n    = 1'b1;
    cs      = 1'b0;
    read_n  = 1'b1;
    write_n = 1'b1;
    // Released bus shows the inverse of the last value
    data_in = ~d;
    repeat (5) @(negedge clk);
  endtask
endmodule // afhp_host_model

// [testbench/adc_fifo_host_port_tb.sv]
`timescale 1ns/1ps
module adc_fifo_host_port_tb;
  import afhp_pkg::*;
  logic       CLK, RST, SAMPLE_VALID, CS_N, CS, READ_N, WRITE_N, SEL_LO, SEL_HI;
  logic       DATA_OE, BLOCK_READY_N, prev_rdy, seen;
  logic [1:0] SCAN_CHANNEL;
  logic [9:0] SAMPLE_CODE, MODE_CHANNEL_CONFIG, DATA_IN, DATA_OUT, mode_now, fmt_now, rdat;
  logic [9:0] q[$];
  logic [9:0] corner[3] = '{10'h3FF, 10'h200, 10'h000};
  int         n_mismatch, checked, n_pulse, n_low, cycles, skip, nch;
  int         tl1[4] = '{1, 4, 8, 14};

  afhp_top uut (.CLK(CLK), .RST(RST), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_CODE(SAMPLE_CODE),
    .SCAN_CHANNEL(SCAN_CHANNEL), .MODE_CHANNEL_CONFIG(MODE_CHANNEL_CONFIG),
    .CHIP_SELECT_LOW_ACTIVE_N(CS_N), .CHIP_SELECT_HIGH_ACTIVE(CS), .READ_N(READ_N),
    .WRITE_N(WRITE_N), .REG_SELECT_LO(SEL_LO), .REG_SELECT_HI(SEL_HI), .DATA_IN(DATA_IN),
    .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .BLOCK_READY_N(BLOCK_READY_N));

  afhp_host_model host (.clk(CLK), .data_out(DATA_OUT), .data_oe(DATA_OE), .cs_n(CS_N),
    .cs(CS), .read_n(READ_N), .write_n(WRITE_N), .sel_lo(SEL_LO), .sel_hi(SEL_HI),
    .data_in(DATA_IN));

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Pulse counter and hang guard, sampled on settled outputs
  always @(negedge CLK) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      complete_run();
    end
    if (!RST && BLOCK_READY_N === 1'b0) begin
      n_low++;
      if (prev_rdy === 1'b1) n_pulse++;
    end
    prev_rdy <= BLOCK_READY_N;
  end

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [9:0] exp_code(input logic [9:0] raw, input logic twos);
    return twos ? raw ^ 10'h200 : raw;
  endfunction

  task automatic push(input logic [9:0] c);
    SAMPLE_VALID = 1'b1;
    SAMPLE_CODE  = c;
    @(negedge CLK);
    SAMPLE_VALID = 1'b0;
    SAMPLE_CODE  = ~c;
    repeat (2) @(negedge CLK);
    if (mode_now[AFHP_M_PD_BIT]) return;
    if (skip > 0) begin
      skip--;
    end else begin
      if (q.size() == AFHP_DEPTH) void'(q.pop_front());
      q.push_back(exp_code(c, fmt_now[AFHP_F_FMT_BIT]));
    end
  endtask

  task automatic cfg(input logic [9:0] m, input logic [9:0] f);
    host.access(AFHP_SEL_MODE, 1'b1, 1'b1, m, rdat, seen);
    chk(MODE_CHANNEL_CONFIG, m, "mode register");
    host.access(AFHP_SEL_FORMAT, 1'b1, 1'b1, f | 10'h002, rdat, seen);
    host.access(AFHP_SEL_FORMAT, 1'b0, 1'b1, 10'h000, rdat, seen);
    chk(rdat, f[AFHP_F_RW_BIT] ? f : 10'h000, "format readback");
    mode_now = m;
    fmt_now  = f;
    q.delete();
    skip = m[AFHP_M_CONV_BIT] ? 0 : 7;
    nch  = m[AFHP_M_SCAN_BIT] ? int'(m[4:3]) + 1 : 1;
  endtask

  // Pushes n results; one pulse expected from push number at (0 for none)
  task automatic run(input int n, input int at);
    int base;
    base = n_pulse;
    for (int i = 1; i <= n; i++) begin
      push(i <= 3 ? corner[i-1] : 10'($urandom));
      chk(10'(n_pulse - base), 10'((at > 0 && i >= at) ? 1 : 0), "pulses");
      if (nch > 1) chk(10'(SCAN_CHANNEL), 10'(i % nch), "scan channel");
    end
    chk(10'(n_low), 10'(n_pulse), "pulse width");
  endtask

  task automatic drain();
    while (q.size() > 0) begin
      host.access(AFHP_SEL_MODE, 1'b0, 1'b1, 10'h000, rdat, seen);
      chk(rdat, q.pop_front(), "buffer word");
    end
  endtask

  initial begin
    RST          = 1'b1;
    SAMPLE_VALID = 1'b0;
    SAMPLE_CODE  = 10'h000;
    prev_rdy     = 1'b1;
    mode_now     = 10'h020;
    fmt_now      = 10'h000;
    void'($urandom(76));
    repeat (4) @(negedge CLK);
    RST = 1'b0;
    repeat (4) @(negedge CLK);
    chk(MODE_CHANNEL_CONFIG, 10'h020, "mode reset value");
    chk(10'({DATA_OE, BLOCK_READY_N, SCAN_CHANNEL}), 10'h004, "idle outputs");
    host.access(2'h2, 1'b1, 1'b1, 10'h3FF, rdat, seen);
    host.access(2'h3, 1'b1, 1'b1, 10'h155, rdat, seen);
    chk(MODE_CHANNEL_CONFIG, 10'h020, "reserved select write");
    for (int c = 0; c < 4; c++) begin
      cfg(10'h002, 10'h040 | 10'(c << AFHP_F_TRIG_LO) | (c[0] ? 10'h080 : 10'h000));
      run(tl1[c], tl1[c]);
      drain();
    end
    // Four-input autoscan, block of four
    cfg(10'h09A, 10'h0C0);
    run(4, 4);
    drain();
    // Continuous mode: seven results lost to latency
    cfg(10'h000, 10'h044);
    run(11, 11);
    drain();
    // Test voltage selected: no pulse
    cfg(10'h102, 10'h000);
    run(2, 0);
    drain();
    // No reads until the buffer has wrapped
    cfg(10'h002, 10'h00C);
    run(17, 14);
    drain();
    // Power down keeps the buffer readable
    cfg(10'h002, 10'h000);
    run(1, 1);
    host.access(AFHP_SEL_MODE, 1'b1, 1'b1, 10'h006, rdat, seen);
    mode_now = 10'h006;
    run(1, 0);
    host.access(AFHP_SEL_MODE, 1'b0, 1'b0, 10'h000, rdat, seen);
    chk(10'(seen), 10'h000, "read without high select");
    drain();
    // Device reset bit restores both registers
    host.access(AFHP_SEL_FORMAT, 1'b1, 1'b1, 10'h041, rdat, seen);
    chk(MODE_CHANNEL_CONFIG, AFHP_MODE_RESET, "device reset mode");
    host.access(AFHP_SEL_FORMAT, 1'b0, 1'b1, 10'h000, rdat, seen);
    chk(rdat, AFHP_FORMAT_RESET, "device reset format");
    complete_run();
  end
endmodule // adc_fifo_host_port_tb
